// ### rtl/skip_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "xfer_exec_regs.svh"
module skip_ctrl (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_valid,
    input wire logic i_skip_req,
    input wire logic i_is_xy_imm,
    output logic o_suppress,
    output logic o_skip_reg
);
    logic skip_reg;
    logic last_xy_reg;

    // Current instruction is void if a skip was requested or it repeats an immediate X/Y load
    assign o_suppress = skip_reg || (i_is_xy_imm && last_xy_reg);
    assign o_skip_reg = skip_reg;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            skip_reg <= 1'b0;
        end else if (i_valid) begin
            skip_reg <= i_skip_req && !o_suppress;
        end
    end

    // Chain of back-to-back immediate loads, broken by any other instruction
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            last_xy_reg <= 1'b0;
        end else if (i_valid) begin
            last_xy_reg <= i_is_xy_imm;
        end
    end
endmodule
`default_nettype wire

// ### rtl/xfer_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "xfer_exec_regs.svh"
module xfer_exec (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_valid,
    input wire logic [9:0] i_instr,
    input wire logic [3:0] i_ram_rdata,
    input wire logic [2:0] i_call_stack_pointer,
    input wire logic i_watchdog_flag_one,
    output logic [3:0] o_acc,
    output logic [3:0] o_b,
    output logic [3:0] o_xpointer,
    output logic [3:0] o_ypointer,
    output logic [1:0] o_zpointer,
    output logic [7:0] o_pair_reg,
    output logic [2:0] o_page_reg,
    output logic [23:0] o_timer_ctrl,
    output logic o_ram_we,
    output logic [3:0] o_ram_wdata,
    output logic o_watchdog_clear,
    output logic o_skip_pending
);
    // ****************************************
    // Decode
    // ****************************************
    xfer_exec_pkg::core_regs_t r_reg;
    xfer_exec_pkg::ram_wr_t ram_reg;
    logic [7:0] e_reg;
    logic [2:0] d_reg;
    logic [23:0] tctrl_reg;
    logic wclr_reg;
    logic suppress;
    logic skip_q;
    logic skip_req;
    logic go;
    logic [3:0] j;
    logic [3:0] y_inc;
    logic [3:0] y_dec;
    logic is_ld, is_sw, is_swd, is_swi, is_st, is_mem, is_xy;
    logic [5:0] tw_hit;

    assign j = i_instr[3:0];
    assign y_inc = r_reg.y + 4'h1;
    assign y_dec = r_reg.y - 4'h1;
    assign is_ld = i_instr[9:4] == `OP_MEM_LD_HI;
    assign is_sw = i_instr[9:4] == `OP_MEM_SW_HI;
    assign is_swd = i_instr[9:4] == `OP_MEM_SWD_HI;
    assign is_swi = i_instr[9:4] == `OP_MEM_SWI_HI;
    assign is_st = i_instr[9:4] == `OP_MEM_ST_HI;
    assign is_mem = is_ld || is_sw || is_swd || is_swi || is_st;
    assign is_xy = i_instr[9:8] == `OP_XY_IMM_HI;
    assign go = i_valid && !suppress;

    assign tw_hit[0] = i_instr == `OP_WR_TCTRL1;
    assign tw_hit[1] = i_instr == `OP_WR_TCTRL2;
    assign tw_hit[2] = i_instr == `OP_WR_TCTRL3;
    assign tw_hit[3] = i_instr == `OP_WR_TCTRL4;
    assign tw_hit[4] = i_instr == `OP_WR_TCTRL5;
    assign tw_hit[5] = i_instr == `OP_WR_TCTRL6;

    // Skip requests from the instructions handled here
    always_comb begin
        skip_req = 1'b0;
        if (i_instr == `OP_WDOG_CLR) begin
            skip_req = i_watchdog_flag_one;
        end else if (i_instr == `OP_INC_Y || is_swi) begin
            skip_req = y_inc == `NIB_ZERO;
        end else if (i_instr == `OP_DEC_Y || is_swd) begin
            skip_req = y_dec == `NIB_ALL_ONES;
        end
    end

    skip_ctrl u_skip (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_valid(i_valid),
        .i_skip_req(skip_req),
        .i_is_xy_imm(is_xy),
        .o_suppress(suppress),
        .o_skip_reg(skip_q)
    );

    // ****************************************
    // Accumulator and B
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            r_reg.acc <= `NIB_ZERO;
        end else if (go) begin
            if (is_ld || is_sw || is_swd || is_swi) begin
                r_reg.acc <= i_ram_rdata;
            end else if (i_instr == `OP_ACC_FROM_B) begin
                r_reg.acc <= r_reg.b;
            end else if (i_instr == `OP_Y_TO_ACC) begin
                r_reg.acc <= r_reg.y;
            end else if (i_instr == `OP_X_RD) begin
                r_reg.acc <= r_reg.x;
            end else if (i_instr == `OP_PAIR_RD) begin
                r_reg.acc <= e_reg[3:0];
            end else if (i_instr == `OP_PAGE_RD) begin
                r_reg.acc <= {1'b0, d_reg};
            end else if (i_instr == `OP_Z_RD) begin
                r_reg.acc <= {2'b00, r_reg.z};
            end else if (i_instr == `OP_SP_RD) begin
                r_reg.acc <= {1'b0, i_call_stack_pointer};
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            r_reg.b <= `NIB_ZERO;
        end else if (go) begin
            if (i_instr == `OP_ACC_TO_B) begin
                r_reg.b <= r_reg.acc;
            end else if (i_instr == `OP_PAIR_RD) begin
                r_reg.b <= e_reg[7:4];
            end
        end
    end

    // ****************************************
    // Data pointer
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            r_reg.x <= `NIB_ZERO;
        end else if (go) begin
            if (is_mem) begin
                r_reg.x <= r_reg.x ^ j;
            end else if (is_xy) begin
                r_reg.x <= i_instr[7:4];
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            r_reg.y <= `NIB_ZERO;
        end else if (go) begin
            if (i_instr == `OP_INC_Y || is_swi) begin
                r_reg.y <= y_inc;
            end else if (i_instr == `OP_DEC_Y || is_swd) begin
                r_reg.y <= y_dec;
            end else if (i_instr == `OP_ACC_TO_Y) begin
                r_reg.y <= r_reg.acc;
            end else if (is_xy) begin
                r_reg.y <= i_instr[3:0];
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            r_reg.z <= 2'b00;
        end else if (go && i_instr[9:2] == `OP_Z_IMM_HI) begin
            r_reg.z <= i_instr[1:0];
        end
    end

    // ****************************************
    // Pair and page registers
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            e_reg <= `RST_E;
        end else if (go && i_instr == `OP_PAIR_WR) begin
            e_reg <= {r_reg.b, r_reg.acc};
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            d_reg <= `RST_D;
        end else if (go && i_instr == `OP_PAGE_WR) begin
            d_reg <= r_reg.acc[2:0];
        end
    end

    // ****************************************
    // Timer control registers
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_tw
            always_ff @(posedge i_mclk) begin
                if (i_rst) begin
                    tctrl_reg[g*4 +: 4] <= `NIB_ZERO;
                end else if (go && tw_hit[g]) begin
                    tctrl_reg[g*4 +: 4] <= r_reg.acc;
                end
            end
        end
    endgenerate

    // ****************************************
    // RAM write and watchdog clear
    // ****************************************
    // Write data is the accumulator before this instruction's swap
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ram_reg <= '0;
        end else begin
            ram_reg.we <= go && (is_sw || is_swd || is_swi || is_st);
            ram_reg.wdata <= r_reg.acc;
        end
    end

    // Flag clear only when the skip is taken, so a clear flag stays untouched
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            wclr_reg <= 1'b0;
        end else begin
            wclr_reg <= go && i_instr == `OP_WDOG_CLR && i_watchdog_flag_one;
        end
    end

    assign o_acc = r_reg.acc;
    assign o_b = r_reg.b;
    assign o_xpointer = r_reg.x;
    assign o_ypointer = r_reg.y;
    assign o_zpointer = r_reg.z;
    assign o_pair_reg = e_reg;
    assign o_page_reg = d_reg;
    assign o_timer_ctrl = tctrl_reg;
    assign o_ram_we = ram_reg.we;
    assign o_ram_wdata = ram_reg.wdata;
    assign o_watchdog_clear = wclr_reg;
    assign o_skip_pending = skip_q;

    // ****************************************
    // Checks
    // ****************************************
    property p_tw1;
        @(posedge i_mclk) disable iff (i_rst)
        (go && i_instr == `OP_WR_TCTRL1) |=> o_timer_ctrl[3:0] == $past(o_acc);
    endproperty
    a_tw1: assert property (p_tw1) else $error("timer ctrl one not written");

    property p_wdog;
        @(posedge i_mclk) disable iff (i_rst)
        (go && i_instr == `OP_WDOG_CLR && i_watchdog_flag_one) |=> o_skip_pending && o_watchdog_clear;
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog skip or clear missing");

    property p_swap;
        @(posedge i_mclk) disable iff (i_rst)
        (go && is_sw) |=> o_acc == $past(i_ram_rdata) && o_ram_we && o_ram_wdata == $past(o_acc);
    endproperty
    a_swap: assert property (p_swap) else $error("swap wrong");

    property p_inc_skip;
        @(posedge i_mclk) disable iff (i_rst)
        (go && i_instr == `OP_INC_Y) |=> o_skip_pending == (o_ypointer == 4'h0);
    endproperty
    a_inc_skip: assert property (p_inc_skip) else $error("increment skip wrong");

    property p_dec_skip;
        @(posedge i_mclk) disable iff (i_rst)
        (go && is_swd) |=> o_skip_pending == (o_ypointer == 4'hF);
    endproperty
    a_dec_skip: assert property (p_dec_skip) else $error("decrement skip wrong");

    property p_ld_x;
        @(posedge i_mclk) disable iff (i_rst)
        (go && is_ld) |=> o_xpointer == ($past(o_xpointer) ^ $past(j)) && !o_ram_we;
    endproperty
    a_ld_x: assert property (p_ld_x) else $error("load x update wrong");

    sequence s_pair_wr;
        go && i_instr == `OP_PAIR_WR;
    endsequence
    sequence s_pair_rd;
        go && i_instr == `OP_PAIR_RD;
    endsequence
    sequence s_xy_taken;
        i_valid && is_xy && !suppress;
    endsequence
    sequence s_xy_again;
        i_valid && is_xy;
    endsequence

    property p_pair;
        @(posedge i_mclk) disable iff (i_rst)
        s_pair_wr ##1 s_pair_rd |=> o_b == $past(o_b, 2) && o_acc == $past(o_acc, 2);
    endproperty
    a_pair: assert property (p_pair) else $error("pair round trip wrong");

    property p_xy_chain;
        @(posedge i_mclk) disable iff (i_rst)
        s_xy_taken ##1 s_xy_again |=> o_xpointer == $past(o_xpointer);
    endproperty
    a_xy_chain: assert property (p_xy_chain) else $error("repeated xy load executed");

    property p_skip_noop;
        @(posedge i_mclk) disable iff (i_rst)
        (o_skip_pending && i_valid) |=> $stable(o_acc) && $stable(o_ypointer) && !o_ram_we;
    endproperty
    a_skip_noop: assert property (p_skip_noop) else $error("skipped instruction had effect");

    property p_inc_wrap;
        @(posedge i_mclk) disable iff (i_rst)
        (go && is_swi) |=> (o_ypointer == ($past(o_ypointer) + 4'h1)) && (o_skip_pending == (o_ypointer == 4'h0));
    endproperty
    a_inc_wrap: assert property (p_inc_wrap) else $error("swap increment skip wrong");

    property p_dey_skip;
        @(posedge i_mclk) disable iff (i_rst)
        (go && i_instr == `OP_DEC_Y) |=> (o_ypointer == ($past(o_ypointer) - 4'h1)) && (o_skip_pending == (o_ypointer == 4'hF));
    endproperty
    a_dey_skip: assert property (p_dey_skip) else $error("y decrement skip wrong");

    property p_store;
        @(posedge i_mclk) disable iff (i_rst)
        (go && is_st) |=> o_ram_we && o_ram_wdata == $past(o_acc) && $stable(o_acc);
    endproperty
    a_store: assert property (p_store) else $error("store wrong");

    property p_page_rd;
        @(posedge i_mclk) disable iff (i_rst)
        (go && i_instr == `OP_PAGE_RD) |=> o_acc == {1'b0, $past(o_page_reg)};
    endproperty
    a_page_rd: assert property (p_page_rd) else $error("page read wrong");

    property p_z_rd;
        @(posedge i_mclk) disable iff (i_rst)
        (go && i_instr == `OP_Z_RD) |=> o_acc == {2'b00, $past(o_zpointer)};
    endproperty
    a_z_rd: assert property (p_z_rd) else $error("z read wrong");

    property p_z_imm;
        @(posedge i_mclk) disable iff (i_rst)
        (go && i_instr[9:2] == `OP_Z_IMM_HI) |=> o_zpointer == $past(i_instr[1:0]);
    endproperty
    a_z_imm: assert property (p_z_imm) else $error("z immediate load wrong");
endmodule
`default_nettype wire

// ### rtl/xfer_exec_pkg.sv
`default_nettype none
package xfer_exec_pkg;
    typedef struct packed {
        logic [3:0] acc;
        logic [3:0] b;
        logic [3:0] x;
        logic [3:0] y;
        logic [1:0] z;
    } core_regs_t;

    typedef struct packed {
        logic       we;
        logic [3:0] wdata;
    } ram_wr_t;
endpackage
`default_nettype wire

// ### rtl/xfer_exec_regs.svh
`ifndef XFER_EXEC_REGS_SVH
`define XFER_EXEC_REGS_SVH
// Opcode patterns of the decoded instruction word, nibble constants and reset values
`define OP_WR_TCTRL1   10'h20E
`define OP_WR_TCTRL2   10'h20F
`define OP_WR_TCTRL3   10'h210
`define OP_WR_TCTRL4   10'h211
`define OP_WR_TCTRL5   10'h212
`define OP_WR_TCTRL6   10'h213
`define OP_WDOG_CLR    10'h2A0
`define OP_ACC_FROM_B  10'h01E
`define OP_ACC_TO_B    10'h00E
`define OP_Y_TO_ACC    10'h01F
`define OP_ACC_TO_Y    10'h00C
`define OP_PAIR_WR     10'h01A
`define OP_PAIR_RD     10'h02A
`define OP_PAGE_WR     10'h029
`define OP_PAGE_RD     10'h051
`define OP_Z_RD        10'h053
`define OP_X_RD        10'h052
`define OP_SP_RD       10'h050
`define OP_INC_Y       10'h013
`define OP_DEC_Y       10'h017
`define OP_Z_IMM_HI    8'h12
`define OP_MEM_LD_HI   6'h2C
`define OP_MEM_SW_HI   6'h2D
`define OP_MEM_SWD_HI  6'h2F
`define OP_MEM_SWI_HI  6'h2E
`define OP_MEM_ST_HI   6'h2B
`define OP_XY_IMM_HI   2'h3
`define NIB_ZERO       4'h0
`define NIB_ALL_ONES   4'hF
`define RST_E          8'h00
`define RST_D          3'h0
`endif

// ### sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "xfer_exec_regs.svh"
module testbench;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic i_valid = 1'b0;
    logic [9:0] i_instr = 10'h000;
    logic [3:0] i_ram_rdata = 4'h0;
    logic [2:0] i_call_stack_pointer = 3'h6;
    logic i_watchdog_flag_one = 1'b0;
    logic [3:0] o_acc, o_b, o_xpointer, o_ypointer;
    logic [1:0] o_zpointer;
    logic [7:0] o_pair_reg;
    logic [2:0] o_page_reg;
    logic [23:0] o_timer_ctrl;
    logic o_ram_we, o_watchdog_clear, o_skip_pending;
    logic [3:0] o_ram_wdata;
    int n_fail = 0;
    int num_checks = 0;

    xfer_exec i_xfer_exec (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_valid(i_valid), .i_instr(i_instr),
        .i_ram_rdata(i_ram_rdata), .i_call_stack_pointer(i_call_stack_pointer),
        .i_watchdog_flag_one(i_watchdog_flag_one), .o_acc(o_acc), .o_b(o_b),
        .o_xpointer(o_xpointer), .o_ypointer(o_ypointer), .o_zpointer(o_zpointer),
        .o_pair_reg(o_pair_reg), .o_page_reg(o_page_reg), .o_timer_ctrl(o_timer_ctrl),
        .o_ram_we(o_ram_we), .o_ram_wdata(o_ram_wdata), .o_watchdog_clear(o_watchdog_clear),
        .o_skip_pending(o_skip_pending)
    );

    initial begin
        forever #25 i_mclk = ~i_mclk;
    end

    // ****************
    // Shared tasks
    // ****************
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One valid cycle, then an idle one; outputs settle before return
    task automatic issue(input logic [9:0] ins, input logic [3:0] m);
        @(posedge i_mclk);
        i_instr <= ins;
        i_valid <= 1'b1;
        i_ram_rdata <= m;
        @(posedge i_mclk);
        i_valid <= 1'b0;
        #1;
    endtask

    task automatic final_report();
        $display("checks=%0d fails=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic t_reset();
        chk({o_acc, o_b, o_xpointer, o_ypointer, o_pair_reg}, 24'h00_0000);
        chk(o_timer_ctrl, 24'h00_0000);
        chk({o_zpointer, o_page_reg, o_ram_we, o_watchdog_clear, o_skip_pending}, 24'h00_0000);
    endtask

    task automatic t_copy();
        issue(10'h339, 4'h0);
        issue(10'h2C5, 4'hA);
        chk({o_acc, o_xpointer, 3'h0, o_ram_we}, 24'h00_0A60);
        issue(`OP_ACC_TO_B, 4'h0);
        chk({o_b, o_acc}, 24'hAA);
        issue(10'h2C0, 4'h4);
        issue(`OP_PAIR_WR, 4'h0);
        chk(o_pair_reg, 24'hA4);
        issue(`OP_ACC_FROM_B, 4'h0);
        chk({o_b, o_acc}, 24'hAA);
        issue(`OP_Y_TO_ACC, 4'h0);
        chk({o_acc, o_ypointer}, 24'h99);
        issue(`OP_X_RD, 4'h0);
        chk({o_acc, o_xpointer}, 24'h66);
        issue(10'h2C0, 4'hC);
        issue(`OP_ACC_TO_Y, 4'h0);
        chk({o_acc, o_ypointer}, 24'hCC);
        issue(`OP_PAIR_RD, 4'h0);
        chk({o_b, o_acc, o_pair_reg}, 24'hA4A4);
    endtask

    task automatic t_page();
        issue(10'h2C0, 4'hD);
        issue(`OP_PAGE_WR, 4'h0);
        chk(o_page_reg, 24'h5);
        issue(10'h2C0, 4'hF);
        issue(`OP_PAGE_RD, 4'h0);
        chk(o_acc, 24'h5);
        issue({`OP_Z_IMM_HI, 2'h2}, 4'h0);
        chk(o_zpointer, 24'h2);
        issue(10'h2C0, 4'hF);
        issue(`OP_Z_RD, 4'h0);
        chk(o_acc, 24'h2);
        issue(10'h2C0, 4'hF);
        issue(`OP_SP_RD, 4'h0);
        chk(o_acc, 24'h6);
    endtask

    task automatic t_timer();
        logic [23:0] exp;
        exp = 24'h00_0000;
        for (int k = 0; k < 6; k++) begin
            issue(10'h2C0, 4'(k + 9));
            issue(`OP_WR_TCTRL1 + 10'(k), 4'h0);
            exp[4*k +: 4] = 4'(k + 9);
        end
        chk(o_timer_ctrl, exp);
    endtask

    task automatic t_mem();
        issue(10'h2C0, 4'h3);
        issue({`OP_MEM_SW_HI, 4'hF}, 4'h8);
        chk({o_acc, o_xpointer, o_ram_wdata, 3'h0, o_ram_we}, 24'h89_31);
        @(posedge i_mclk);
        #1;
        chk(o_ram_we, 24'h0);
        issue({`OP_MEM_ST_HI, 4'h1}, 4'h2);
        chk({o_acc, o_xpointer, o_ram_wdata, 3'h0, o_ram_we}, 24'h88_81);
    endtask

    // Each skip is followed by a load or a Y step that must have no effect
    task automatic t_skip();
        issue(10'h300, 4'h0);
        issue({`OP_MEM_SWD_HI, 4'h3}, 4'h1);
        chk({o_acc, o_xpointer, o_ypointer, 3'h0, o_skip_pending}, 24'h13F_1);
        issue(10'h2C5, 4'h7);
        chk({o_acc, o_xpointer, 3'h0, o_skip_pending}, 24'h13_0);
        issue({`OP_MEM_SWI_HI, 4'h0}, 4'h2);
        chk({o_acc, o_ypointer, 3'h0, o_skip_pending}, 24'h20_1);
        issue(`OP_INC_Y, 4'h0);
        chk({o_ypointer, 3'h0, o_skip_pending}, 24'h0_0);
        issue(`OP_INC_Y, 4'h0);
        chk({o_ypointer, 3'h0, o_skip_pending}, 24'h1_0);
        issue(`OP_DEC_Y, 4'h0);
        chk({o_ypointer, 3'h0, o_skip_pending}, 24'h0_0);
        issue(`OP_DEC_Y, 4'h0);
        chk({o_ypointer, 3'h0, o_skip_pending}, 24'hF_1);
        issue(10'h2C0, 4'h9);
        chk(o_acc, 24'h2);
        issue(`OP_INC_Y, 4'h0);
        chk({o_ypointer, 3'h0, o_skip_pending}, 24'h0_1);
        issue(`OP_DEC_Y, 4'h0);
        chk({o_ypointer, 3'h0, o_skip_pending}, 24'h0_0);
    endtask

    task automatic t_wdog();
        issue(`OP_WDOG_CLR, 4'h0);
        chk({o_watchdog_clear, o_skip_pending}, 24'h0);
        @(posedge i_mclk);
        i_watchdog_flag_one <= 1'b1;
        issue(`OP_WDOG_CLR, 4'h0);
        chk({o_watchdog_clear, o_skip_pending}, 24'h3);
        @(posedge i_mclk);
        i_watchdog_flag_one <= 1'b0;
        issue(10'h2C0, 4'h9);
        chk({o_acc, o_watchdog_clear, o_skip_pending}, 24'h08);
    endtask

    // Back-to-back loads: only the first takes effect; then a back-to-back pair round trip
    task automatic t_chain();
        @(posedge i_mclk);
        i_instr <= 10'h312;
        i_valid <= 1'b1;
        @(posedge i_mclk);
        i_instr <= 10'h345;
        @(posedge i_mclk);
        i_valid <= 1'b0;
        #1;
        chk({o_xpointer, o_ypointer}, 24'h12);
        issue(`OP_X_RD, 4'h0);
        issue(10'h378, 4'h0);
        chk({o_acc, o_xpointer, o_ypointer}, 24'h178);
        @(posedge i_mclk);
        i_instr <= `OP_PAIR_WR;
        i_valid <= 1'b1;
        @(posedge i_mclk);
        i_instr <= `OP_PAIR_RD;
        @(posedge i_mclk);
        i_valid <= 1'b0;
        #1;
        chk({o_b, o_acc, o_pair_reg}, 24'h00_A1A1);
    endtask

    // ****************
    // Main sequence
    // ****************
    initial begin
        repeat (8) @(posedge i_mclk);
        i_rst <= 1'b0;
        #1;
        t_reset();
        t_copy();
        t_page();
        t_timer();
        t_mem();
        t_skip();
        t_wdog();
        t_chain();
        final_report();
    end

    // Whole run needs about 120 cycles; this is far past that
    initial begin
        #100000;
        n_fail++;
        final_report();
    end
endmodule
`default_nettype wire
